// ===== design/ptc_regs.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

// Register byte offsets (8-bit port, one register per address)
`define PTC_ADDR_CTRL 4'h0
`define PTC_ADDR_CNT_LO 4'h1
`define PTC_ADDR_CNT_HI 4'h2
`define PTC_ADDR_IRQ_STAT 4'h3
`define PTC_ADDR_IRQ_MASK 4'h4

// Control register fields
`define PTC_BIT_RUN 7
`define PTC_BIT_NARROW 6
`define PTC_BIT_SRC 5
`define PTC_BIT_EDGE 4
`define PTC_BIT_BYPASS 3
`define PTC_RATIO_MSB 2
`define PTC_RATIO_LSB 0

// Interrupt status/mask fields
`define PTC_BIT_OVF 0

// Reset values
`define PTC_CTRL_RESET 8'hff
`define PTC_MASK_RESET 8'h00

// Internal count tick: oscillator divided by four
`define PTC_INT_DIV 2'h3

`endif

// ===== design/ptc_pkg.sv
// Types shared by the timer block files
package ptc_pkg;

  // Control register layout
  typedef struct packed {
    logic run;
    logic narrow;
    logic src_ext;
    logic edge_fall;
    logic bypass;
    logic [2:0] ratio;
  } ptc_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptc_req_t;

  // Synchroniser states for the edge detector
  typedef enum logic [1:0] {
    PTC_EDGE_IDLE = 2'b00,
    PTC_EDGE_SEEN = 2'b01
  } ptc_edge_t;

endpackage

// ===== design/ptc_pin_edge.sv
// Pin synchroniser with selectable edge detection for the external count input
`timescale 1ns/100ps
module ptc_pin_edge
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin_in,
  input wire logic edge_fall,
  output logic edge_pulse
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic sync1_nxt;
  logic sync2_nxt;
  logic prev_nxt;

  // Two-stage synchroniser, then history for edge detection
  always_comb
  begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Falling edge when selected, rising edge otherwise
  assign edge_pulse = edge_fall ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);

endmodule

// ===== design/ptc_prescaler.sv
// Programmable 8-bit prescaler, divides a tick stream by 2 to 256
`timescale 1ns/100ps
module ptc_prescaler
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [2:0] ratio,
  output logic tick_out
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] top;

  // Ratio code n divides by 2^(n+1); top is divisor minus one
  assign top = 8'((9'h002 << ratio) - 9'h001);

  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_out = 1'b0;
    if (clear)
    begin
      cnt_nxt = 8'h00;
    end
    else if (tick_in)
    begin
      if (cnt_r >= top)
      begin
        cnt_nxt = 8'h00;
        tick_out = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

// ===== design/ptc_timer.sv
// Prescaled 8/16-bit timer/counter with control register, counter access and interrupt
//
// Overview of operation
// - The counter advances only while the run-enable bit is one and holds its value when it is zero.
// - The narrow bit selects 8-bit counting when set and 16-bit when clear, and a wrap sets the overflow flag.
// - The source bit selects edges of the external count pin when set and the oscillator divided by four when clear.
// - With the external source, the edge bit selects falling edges when set and rising edges when clear.
// - The 8-bit prescaler divides by 256 for code 111, 128 for code 110 and 4 for code 001.
// - The control register is fully readable and writable and all eight bits reset to one.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "ptc_regs.svh"
module ptc_timer
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  output logic irq
);

  // ---------------------------------------------------------------
  // Request bundle
  // ---------------------------------------------------------------
  ptc_pkg::ptc_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_stat;
  logic wr_mask;

  // Address decode for writes
  always_comb
  begin
    wr_ctrl = req.wr && (req.addr == `PTC_ADDR_CTRL);
    wr_lo = req.wr && (req.addr == `PTC_ADDR_CNT_LO);
    wr_hi = req.wr && (req.addr == `PTC_ADDR_CNT_HI);
    wr_stat = req.wr && (req.addr == `PTC_ADDR_IRQ_STAT);
    wr_mask = req.wr && (req.addr == `PTC_ADDR_IRQ_MASK);
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  ptc_pkg::ptc_ctrl_t ctrl_r;
  ptc_pkg::ptc_ctrl_t ctrl_nxt;

  // Software writes the whole byte; every bit is read back
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
      ctrl_nxt = ptc_pkg::ptc_ctrl_t'(req.wdata);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ctrl_r <= ptc_pkg::ptc_ctrl_t'(`PTC_CTRL_RESET);
    else
      ctrl_r <= ctrl_nxt;
  end

  // ---------------------------------------------------------------
  // Count source selection
  // ---------------------------------------------------------------
  logic [1:0] qdiv_r;
  logic [1:0] qdiv_nxt;
  logic int_tick;
  logic ext_tick;
  logic src_tick;
  logic pre_tick;
  logic cnt_tick;

  // Internal instruction tick, one in four system clocks
  always_comb
  begin
    qdiv_nxt = qdiv_r + 2'h1;
    int_tick = (qdiv_r == `PTC_INT_DIV);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      qdiv_r <= 2'h0;
    else
      qdiv_r <= qdiv_nxt;
  end

  ptc_pin_edge u_pin_edge
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in(external_count_pin),
    .edge_fall(ctrl_r.edge_fall),
    .edge_pulse(ext_tick)
  );

  // Pin edges or internal tick; pin edges need two clocks of sync latency
  assign src_tick = ctrl_r.src_ext ? ext_tick : int_tick;

  // Counter writes also clear the prescaler so the next period starts fresh
  ptc_prescaler u_prescaler
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(wr_lo | wr_hi | wr_ctrl),
    .tick_in(src_tick & ctrl_r.run),
    .ratio(ctrl_r.ratio),
    .tick_out(pre_tick)
  );

  // Bypass skips the prescaler entirely
  assign cnt_tick = ctrl_r.bypass ? src_tick : pre_tick;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic ovf;

  // Software write wins over a count in the same cycle
  always_comb
  begin
    cnt_nxt = cnt_r;
    ovf = 1'b0;
    if (wr_lo)
      cnt_nxt[7:0] = req.wdata;
    else if (wr_hi)
      cnt_nxt[15:8] = req.wdata;
    else if (ctrl_r.run && cnt_tick)
    begin
      if (ctrl_r.narrow)
      begin
        cnt_nxt[7:0] = cnt_r[7:0] + 8'h01;
        ovf = (cnt_r[7:0] == 8'hff);
      end
      else
      begin
        cnt_nxt = cnt_r + 16'h0001;
        ovf = (cnt_r == 16'hffff);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_nxt;
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;

  // Write one to clear; a new overflow in the same cycle wins
  always_comb
  begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_stat)
      stat_nxt = stat_r & ~req.wdata;
    if (ovf)
      stat_nxt[`PTC_BIT_OVF] = 1'b1;
    stat_nxt[7:1] = 7'h00;
    if (wr_mask)
      mask_nxt = req.wdata & 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stat_r <= 8'h00;
      mask_r <= `PTC_MASK_RESET;
    end
    else
    begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign irq = |(stat_r & mask_r);

  // ---------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ---------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        `PTC_ADDR_CTRL: rdata_nxt = ctrl_r;
        `PTC_ADDR_CNT_LO: rdata_nxt = cnt_r[7:0];
        `PTC_ADDR_CNT_HI: rdata_nxt = cnt_r[15:8];
        `PTC_ADDR_IRQ_STAT: rdata_nxt = stat_r;
        `PTC_ADDR_IRQ_MASK: rdata_nxt = mask_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_hold_stopped: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ctrl_r.run && !wr_lo && !wr_hi) |=> (cnt_r == $past(cnt_r)))
    else $error("count moved while stopped");

  chk_narrow_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.narrow && ovf && !wr_stat) |=> (stat_r[0] && cnt_r[7:0] == 8'h00))
    else $error("8-bit wrap did not flag overflow");

  chk_wide_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ctrl_r.narrow && ovf) |=> (stat_r[0] && cnt_r == 16'h0000))
    else $error("16-bit wrap did not flag overflow");

  chk_src_int: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ctrl_r.src_ext) |-> (src_tick == (qdiv_r == 2'h3)))
    else $error("internal tick not one in four");

  chk_ext_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.src_ext && src_tick) |-> (ctrl_r.edge_fall ? !u_pin_edge.sync2_r
      : u_pin_edge.sync2_r))
    else $error("wrong pin edge counted");

  chk_bypass_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.bypass && ctrl_r.run && src_tick && !req.wr) |=>
      (cnt_r != $past(cnt_r)))
    else $error("bypass tick not counted");

  chk_pre_div2: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.ratio == 3'h0) |-> (u_prescaler.top == 8'h01))
    else $error("ratio 000 not divide by 2");

  chk_pre_div256: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.ratio == 3'h7) |-> (u_prescaler.top == 8'hff))
    else $error("ratio 111 not divide by 256");

  chk_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctrl |=> (ctrl_r == $past(req.wdata)))
    else $error("control write lost");

  chk_ovf_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
    ovf |=> stat_r[0])
    else $error("overflow lost against a status clear");

  chk_ovf_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_stat && req.wdata[0] && !ovf) |=> !stat_r[0])
    else $error("overflow flag not cleared by write one");

  chk_narrow_hi_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.narrow && !wr_hi) |=> (cnt_r[15:8] == $past(cnt_r[15:8])))
    else $error("high byte moved in 8-bit mode");

  chk_wide_carry: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ctrl_r.narrow && ctrl_r.run && cnt_tick && !wr_lo && !wr_hi) |=>
      (cnt_r == $past(cnt_r) + 16'h0001))
    else $error("16-bit count did not step by one");

  chk_pre_div4: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.ratio == 3'h1) |-> (u_prescaler.top == 8'h03))
    else $error("ratio 001 not divide by 4");

  chk_pre_div128: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.ratio == 3'h6) |-> (u_prescaler.top == 8'h7f))
    else $error("ratio 110 not divide by 128");

  chk_pre_div64: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctrl_r.ratio == 3'h5) |-> (u_prescaler.top == 8'h3f))
    else $error("ratio 101 not divide by 64");

endmodule

// ===== tb/ptc_pin_model.sv
// External count pin model: drives pulses of varying width
`timescale 1ns/100ps
module ptc_pin_model
(
  input wire logic clk_sys,
  output logic pin
);
  // Pin idles low, so no edge shows before the first pulse
  initial pin = 1'b0;

  // High level lasts 2 to 5 clocks, low level 3 to 6; each level spans at least two synchroniser samples
  task automatic pulses(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      pin <= 1'b1;
      repeat (2 + $urandom_range(3)) @(posedge clk_sys);
      pin <= 1'b0;
      repeat (2 + $urandom_range(3)) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the prescaled timer/counter
`timescale 1ns/100ps
`include "ptc_regs.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic count_pin;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int i;
  int n;
  logic [7:0] v;
  logic [7:0] c;

  // --------------------------------------------------
  // Clock, design and pin model
  // --------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  ptc_timer dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_count_pin(count_pin), .irq(irq));
  ptc_pin_model pm (.clk_sys(clk_sys), .pin(count_pin));

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Tick phase at the start write is free, so one count either way is allowed
  task automatic chk_near(input string name, input int exp, input logic [7:0] got);
    samples_checked++;
    if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1)
    begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %h", name, exp, got);
    end
  endtask

  // Prescaler division for a ratio code
  function automatic int exp_div(input logic [2:0] r);
    return 2 << r;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  // Zero the count, run for cyc clocks after n pin pulses, stop, read low byte
  task automatic run_for(input logic [7:0] cw, input int cyc, input int np,
    output logic [7:0] d);
    wr(`PTC_ADDR_CTRL, 8'h00);
    wr(`PTC_ADDR_CNT_LO, 8'h00);
    wr(`PTC_ADDR_CNT_HI, 8'h00);
    wr(`PTC_ADDR_CTRL, cw);
    if (np > 0)
      pm.pulses(np);
    repeat (cyc) @(posedge clk_sys);
    wr(`PTC_ADDR_CTRL, cw & 8'h7f);
    rd(`PTC_ADDR_CNT_LO, d);
  endtask

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    void'($urandom(74));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`PTC_ADDR_CTRL, v);
    chk("ctrl reset", `PTC_CTRL_RESET, v);
    for (i = 0; i < 5; i++)
    begin
      c = (i == 0) ? 8'h00 : 8'($urandom);
      wr(`PTC_ADDR_CTRL, c);
      rd(`PTC_ADDR_CTRL, v);
      chk("ctrl rw", c, v);
    end
    rd(4'h9, v);
    chk("unmapped", 8'h00, v);
    run_for(8'hc8, 40, 0, v);
    chk_near("int bypass", 10, v);
    repeat (40) @(posedge clk_sys);
    rd(`PTC_ADDR_CNT_LO, c);
    chk("held", v, c);
    chk_near("held near", 10, c);
    for (i = 0; i < 8; i++)
    begin
      run_for(8'hc0 | 8'(i), 16 * exp_div(3'(i)), 0, v);
      chk_near("prescaled", 4, v);
    end
    n = 3 + $urandom_range(5);
    run_for(8'he8, 6, n, v);
    chk("rise edges", 8'(n), v);
    run_for(8'hf8, 6, n, v);
    chk("fall edges", 8'(n), v);
    run_for(8'he0, 6, 2 * n, v);
    chk("ext prescaled", 8'(n), v);
    // Narrow wrap leaves the high byte alone
    wr(`PTC_ADDR_CTRL, 8'h48);
    wr(`PTC_ADDR_IRQ_MASK, 8'h01);
    wr(`PTC_ADDR_CNT_HI, 8'h5a);
    wr(`PTC_ADDR_CNT_LO, 8'hfe);
    wr(`PTC_ADDR_CTRL, 8'hc8);
    repeat (12) @(posedge clk_sys);
    wr(`PTC_ADDR_CTRL, 8'h48);
    chk("irq narrow", 8'h01, {7'h00, irq});
    rd(`PTC_ADDR_CNT_HI, v);
    chk("hi kept", 8'h5a, v);
    rd(`PTC_ADDR_IRQ_STAT, v);
    chk("ovf narrow", 8'h01, v);
    wr(`PTC_ADDR_IRQ_STAT, 8'h01);
    @(negedge clk_sys);
    chk("irq cleared", 8'h00, {7'h00, irq});
    // Wide wrap from the top value
    wr(`PTC_ADDR_CNT_LO, 8'hff);
    wr(`PTC_ADDR_CNT_HI, 8'hff);
    wr(`PTC_ADDR_CTRL, 8'h88);
    repeat (12) @(posedge clk_sys);
    wr(`PTC_ADDR_CTRL, 8'h08);
    rd(`PTC_ADDR_CNT_HI, v);
    chk("wide wrap", 8'h00, v);
    rd(`PTC_ADDR_IRQ_STAT, v);
    chk("ovf wide", 8'h01, v);
    wr(`PTC_ADDR_IRQ_MASK, 8'h00);
    @(negedge clk_sys);
    chk("irq masked", 8'h00, {7'h00, irq});
    // Mid-run reset must bring control, count low byte and mask back, not only at power-on
    wr(`PTC_ADDR_CNT_LO, 8'($urandom));
    wr(`PTC_ADDR_IRQ_MASK, 8'h01);
    rd(`PTC_ADDR_IRQ_MASK, v);
    chk("mask rw", 8'h01, v);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`PTC_ADDR_CTRL, v);
    chk("ctrl reset again", `PTC_CTRL_RESET, v);
    rd(`PTC_ADDR_CNT_LO, v);
    chk("cnt reset", 8'h00, v);
    rd(`PTC_ADDR_IRQ_MASK, v);
    chk("mask reset", `PTC_MASK_RESET, v);
    print_verdict();
  end
endmodule
